/* include/mem_map_pkg.sv */
// Overview of operation
// - Program address is 24 bits from counter/table/window
// - User program access limited to lower half
// - Table page bit 7 opens configuration space
// - Even address lower word, odd upper word
// - Counter word aligned, steps by two
// - Reset fetch at zero, start address at two
// - Two interrupt vector tables at fixed ranges
// - Data effective address is 16-bit byte address
// - Bit 15 clear RAM, set program window
// - Unimplemented data reads return zero
// - Separate read and write address generators
// - Low byte even address, high byte odd
// - Post-increment by one byte, two word
// - Byte read selects lane, placed low
// - Byte write enables only matching lane
// - Odd word access raises address error trap
// - Misaligned read completes; misaligned write suppressed
// - Byte load keeps register high byte
// - Sign extend and zero extend operations
package mem_map_pkg;
   localparam int PA_W = 24;
   localparam int PC_W = 23;
   localparam int EA_W = 16;
   localparam logic [23:0] RESET_VEC      = 24'h000000;
   localparam logic [23:0] START_VEC      = 24'h000002;
   localparam logic [23:0] VEC_RSV_END    = 24'h000200;
   localparam logic [23:0] IVT_BASE       = 24'h000004;
   localparam logic [23:0] IVT_END        = 24'h0000FF;
   localparam logic [23:0] AIVT_BASE      = 24'h000100;
   localparam logic [23:0] AIVT_END       = 24'h0001FF;
   localparam logic [23:0] USER_PA_MAX    = 24'h7FFFFF;
   localparam int          TABLE_PAGE_REGISTER_CFG_BIT = 7;
   localparam int          WIN_BIT        = 15;
   localparam int          RAM_BYTES      = 1024;
   localparam logic [22:0] PC_STEP        = 23'h000002;
   localparam logic [15:0] BYTE_STEP      = 16'h0001;
   localparam logic [15:0] WORD_STEP      = 16'h0002;

   typedef enum logic [1:0] {
      PSRC_PC   = 2'h0,
      PSRC_TBL  = 2'h1,
      PSRC_WIN  = 2'h3
   } psrc_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        byte_op;
      logic        post_inc;
      logic [15:0] effective_address;
      logic [15:0] wdata;
   } dreq_s;

   typedef struct packed {
      logic [22:0] program_counter;
      logic        trap_pend;
      logic [15:0] rdata;
      logic        rvalid;
      logic [15:0] rd_ptr;
      logic [15:0] wr_ptr;
   } state_s;
endpackage

/* hw/memory_map_access_align.sv */
`timescale 1ns/1ps
module memory_map_access_align #(
   parameter int RAM_BYTES = mem_map_pkg::RAM_BYTES
) (
   input  wire logic                 clk_i,          // Core clock
   input  wire logic                 sys_rst_i,      // Sync reset, high
   // Program side
   input  wire logic                 pc_step_i,      // Advance counter
   input  wire logic                 pc_down_i,      // Step downward
   input  wire logic                 pc_load_i,      // Load counter
   input  wire logic [22:0]          pc_load_val_i,  // Branch target
   input  wire mem_map_pkg::psrc_e   psrc_i,         // Address source
   input  wire logic [7:0]           table_page_register_i, // Table page
   input  wire logic [15:0]          tbl_offset_i,   // Table offset
   input  wire logic [14:0]          win_page_i,     // Window page bits
   input  wire logic [22:0]          vec_index_i,    // Vector index
   input  wire logic                 vec_alt_i,      // Use second table
   output logic [23:0]               prog_addr_o,    // Program address
   output logic                      prog_addr_ok_o, // Access allowed
   output logic                      prog_upper_o,   // Upper word select
   output logic [23:0]               vec_addr_o,     // Vector address
   output logic [22:0]               program_counter_o, // Counter value
   // Data side
   input  wire mem_map_pkg::dreq_s   rd_req_i,       // Read request
   input  wire mem_map_pkg::dreq_s   wr_req_i,       // Write request
   input  wire logic                 trap_ack_i,     // Trap taken
   output logic [15:0]               rdata_o,        // Read data
   output logic                      rvalid_o,       // Read data valid
   output logic                      win_sel_o,      // Window access
   output logic [15:0]               rd_ptr_o,       // Read pointer
   output logic [15:0]               wr_ptr_o,       // Write pointer
   output logic                      addr_trap_o,    // Address error trap
   // Working register byte helpers
   input  wire logic [15:0]          wreg_i,         // Register value
   input  wire logic [7:0]           byte_i,         // Byte to load
   input  wire logic [1:0]           ext_op_i,       // 1 sign, 2 zero, 3 load
   output logic [15:0]               wreg_o          // Register result
);
   localparam int WORDS = RAM_BYTES / 2;
   localparam int IDX_W = $clog2(WORDS);

   mem_map_pkg::state_s s_q;
   mem_map_pkg::state_s s_d;
   logic [15:0] ram_q [WORDS];

   // True when a data address lands in implemented RAM
   function automatic logic in_ram(input logic [15:0] ea);
      in_ram = !ea[mem_map_pkg::WIN_BIT] &&
               (32'(ea) < 32'(RAM_BYTES));
   endfunction

   // Word index from a byte address
   function automatic logic [IDX_W-1:0] widx(input logic [15:0] ea);
      widx = ea[IDX_W:1];
   endfunction

   // Pointer step scaled by operand size
   function automatic logic [15:0] step(input logic b);
      step = b ? mem_map_pkg::BYTE_STEP : mem_map_pkg::WORD_STEP;
   endfunction

   logic rd_mis;
   logic wr_mis;
   logic [15:0] rword;
   logic [15:0] lane_mask;

   // Program address source selection
   always_comb begin
      case (psrc_i)
         mem_map_pkg::PSRC_PC:
            prog_addr_o = {1'b0, s_q.program_counter};
         mem_map_pkg::PSRC_TBL:
            prog_addr_o = {table_page_register_i, tbl_offset_i};
         mem_map_pkg::PSRC_WIN:
            prog_addr_o = {1'b0, win_page_i, 8'h00} |
                          {9'h000, rd_req_i.effective_address[14:0]};
         default:
            prog_addr_o = {1'b0, s_q.program_counter};
      endcase
      // Upper half open only to table ops with page bit 7
      prog_addr_ok_o = (prog_addr_o <= mem_map_pkg::USER_PA_MAX) ||
         (psrc_i == mem_map_pkg::PSRC_TBL &&
          table_page_register_i[mem_map_pkg::TABLE_PAGE_REGISTER_CFG_BIT]);
      prog_upper_o = prog_addr_o[0];
   end

   // Vector address: start address, then one of two tables
   always_comb begin
      if (vec_index_i == 23'h000000) begin
         vec_addr_o = mem_map_pkg::START_VEC;
      end else if (vec_alt_i) begin
         vec_addr_o = mem_map_pkg::AIVT_BASE + {vec_index_i[6:0], 1'b0};
      end else begin
         vec_addr_o = mem_map_pkg::IVT_BASE + {vec_index_i[6:0], 1'b0};
      end
   end

   // Alignment checks and lane selection
   always_comb begin
      rd_mis = rd_req_i.valid && !rd_req_i.byte_op &&
               rd_req_i.effective_address[0];
      wr_mis = wr_req_i.valid && !wr_req_i.byte_op &&
               wr_req_i.effective_address[0];
      rword = in_ram(rd_req_i.effective_address) ?
              ram_q[widx(rd_req_i.effective_address)] : 16'h0000;
      if (!wr_req_i.byte_op) begin
         lane_mask = 16'hFFFF;
      end else if (wr_req_i.effective_address[0]) begin
         lane_mask = 16'hFF00;
      end else begin
         lane_mask = 16'h00FF;
      end
   end

   // Next state
   always_comb begin
      s_d = s_q;
      s_d.rvalid = rd_req_i.valid;
      if (pc_load_i) begin
         s_d.program_counter = {pc_load_val_i[22:1], 1'b0};
      end else if (pc_step_i) begin
         s_d.program_counter = pc_down_i ?
            s_q.program_counter - mem_map_pkg::PC_STEP :
            s_q.program_counter + mem_map_pkg::PC_STEP;
      end
      // Misaligned read still completes, data returned
      if (rd_req_i.valid) begin
         if (rd_req_i.byte_op) begin
            s_d.rdata = {8'h00, rd_req_i.effective_address[0] ?
                         rword[15:8] : rword[7:0]};
         end else begin
            s_d.rdata = rword;
         end
      end
      // Independent read and write pointers
      if (rd_req_i.valid) begin
         s_d.rd_ptr = rd_req_i.effective_address +
            (rd_req_i.post_inc ? step(rd_req_i.byte_op) : 16'h0000);
      end
      if (wr_req_i.valid) begin
         s_d.wr_ptr = wr_req_i.effective_address +
            (wr_req_i.post_inc ? step(wr_req_i.byte_op) : 16'h0000);
      end
      // Set wins over acknowledge
      if (trap_ack_i) begin
         s_d.trap_pend = 1'b0;
      end
      if (rd_mis || wr_mis) begin
         s_d.trap_pend = 1'b1;
      end
   end

   // State register; counter starts at reset vector
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
         s_q.program_counter <= mem_map_pkg::RESET_VEC[22:0];
      end else begin
         s_q <= s_d;
      end
   end

   // RAM byte lanes; misaligned word write suppressed
   always_ff @(posedge clk_i) begin
      if (wr_req_i.valid && !wr_mis &&
          in_ram(wr_req_i.effective_address)) begin
         ram_q[widx(wr_req_i.effective_address)] <=
            (ram_q[widx(wr_req_i.effective_address)] & ~lane_mask) |
            ((wr_req_i.byte_op ? {2{wr_req_i.wdata[7:0]}} :
              wr_req_i.wdata) & lane_mask);
      end
   end

   // Byte load, sign extend and zero extend
   always_comb begin
      case (ext_op_i)
         2'h1:    wreg_o = {{8{wreg_i[7]}}, wreg_i[7:0]};
         2'h2:    wreg_o = {8'h00, wreg_i[7:0]};
         2'h3:    wreg_o = {wreg_i[15:8], byte_i};
         default: wreg_o = wreg_i;
      endcase
   end

   assign program_counter_o = s_q.program_counter;
   assign rdata_o           = s_q.rdata;
   assign rvalid_o          = s_q.rvalid;
   assign rd_ptr_o          = s_q.rd_ptr;
   assign wr_ptr_o          = s_q.wr_ptr;
   assign addr_trap_o       = s_q.trap_pend;
   assign win_sel_o = rd_req_i.valid &&
                      rd_req_i.effective_address[mem_map_pkg::WIN_BIT];
endmodule

/* test/mmaa_properties.sv */
`timescale 1ns/1ps
module mmaa_properties #(
   parameter int RAM_BYTES = 1024
) (
   input wire logic               clk_i, sys_rst_i, pc_step_i, // Clk, ctl
   input wire logic               pc_down_i, pc_load_i,        // Counter
   input wire logic [22:0]        program_counter_o, vec_index_i, // Pc
   input wire mem_map_pkg::psrc_e psrc_i,                      // Source
   input wire logic [7:0]         table_page_register_i,       // Page
   input wire logic [23:0]        prog_addr_o, vec_addr_o,     // Address
   input wire logic               prog_addr_ok_o, trap_ack_i,  // Flags
   input wire mem_map_pkg::dreq_s rd_req_i,                    // Read
   input wire logic [15:0]        rdata_o, rd_ptr_o,           // Data
   input wire logic               rvalid_o, win_sel_o, addr_trap_o // Out
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Steps of a misaligned word read and of a held trap
   sequence odd_rd_s;
      rd_req_i.valid && !rd_req_i.byte_op && rd_req_i.effective_address[0];
   endsequence
   sequence trap_idle_s;
      addr_trap_o && !trap_ack_i && !rd_req_i.valid;
   endsequence
   trap_rd_a: assert property (odd_rd_s |=> addr_trap_o)
      else $error("no trap on odd word read");
   trap_hold_a: assert property (trap_idle_s |=> addr_trap_o)
      else $error("trap dropped without ack");
   rvalid_a: assert property (rd_req_i.valid |=> rvalid_o)
      else $error("read answer missing");
   byte_hi_a: assert property (rd_req_i.valid && rd_req_i.byte_op
      |=> rdata_o[15:8] == 8'h00) else $error("byte read high not zero");
   unimpl_zero_a: assert property (rd_req_i.valid &&
      rd_req_i.effective_address >= RAM_BYTES |=> rdata_o == 16'h0000)
      else $error("unimplemented read not zero");
   win_sel_a: assert property (win_sel_o == (rd_req_i.valid &&
      rd_req_i.effective_address[15])) else $error("window select wrong");
   ptr_step_a: assert property (rd_req_i.valid && rd_req_i.post_inc
      |=> rd_ptr_o == $past(rd_req_i.effective_address) +
      ($past(rd_req_i.byte_op) ? 16'h0001 : 16'h0002))
      else $error("pointer step wrong");
   pc_step_a: assert property (pc_step_i && !pc_down_i && !pc_load_i
      |=> program_counter_o == $past(program_counter_o) + 23'h000002)
      else $error("counter step wrong");
   cfg_ok_a: assert property (psrc_i == mem_map_pkg::PSRC_TBL &&
      table_page_register_i[7] |-> prog_addr_ok_o)
      else $error("config space refused");
   user_ok_a: assert property (!prog_addr_o[23] |-> prog_addr_ok_o)
      else $error("user space refused");
   vec_start_a: assert property (vec_index_i == 23'h000000
      |-> vec_addr_o == 24'h000002) else $error("start vector wrong");
endmodule
bind memory_map_access_align mmaa_properties #(.RAM_BYTES(RAM_BYTES)) chk_u (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pc_step_i(pc_step_i),
   .pc_down_i(pc_down_i), .pc_load_i(pc_load_i), .psrc_i(psrc_i),
   .program_counter_o(program_counter_o), .vec_index_i(vec_index_i),
   .table_page_register_i(table_page_register_i), .prog_addr_o(prog_addr_o),
   .vec_addr_o(vec_addr_o), .prog_addr_ok_o(prog_addr_ok_o),
   .trap_ack_i(trap_ack_i), .rd_req_i(rd_req_i), .rdata_o(rdata_o),
   .rd_ptr_o(rd_ptr_o), .rvalid_o(rvalid_o), .win_sel_o(win_sel_o),
   .addr_trap_o(addr_trap_o));

/* test/core_model.sv */
`timescale 1ns/1ps
module core_model (
   input  wire logic          clk_i,    // Core clock
   input  wire logic [15:0]   rdata_i,  // Read data back
   output mem_map_pkg::dreq_s rd_req_o, // Read generator
   output mem_map_pkg::dreq_s wr_req_o  // Write generator
);
   // Both generators idle from time zero, kept apart
   initial begin
      rd_req_o = '0;
      wr_req_o = '0;
   end
   // Read with post increment, 16-bit byte address
   task rd(input logic [15:0] a, input logic b, output logic [15:0] q);
      @(posedge clk_i);
      rd_req_o <= '{1'h1, 1'h0, b, 1'h1, a, 16'h0000};
      @(posedge clk_i);
      rd_req_o.valid <= 1'h0;
      rd_req_o.effective_address <= ~a; // Released bus does not hold
      #1 q = rdata_i;
   endtask
   // Write through its own generator
   task wr(input logic [15:0] a, input logic [15:0] d, input logic b);
      @(posedge clk_i);
      wr_req_o <= '{1'h1, 1'h1, b, 1'h1, a, d};
      @(posedge clk_i);
      wr_req_o.valid <= 1'h0;
      wr_req_o.wdata <= ~d;
      #1;
   endtask
endmodule

/* test/tb_memory_map_access_align.sv */
`timescale 1ns/1ps
module tb_memory_map_access_align;
   logic               clk_i = 1'h0, sys_rst_i = 1'h1, trap_ack_i = 1'h0;
   logic               pc_step_i = 1'h0, pc_down_i = 1'h0, pc_load_i = 1'h0;
   logic               vec_alt_i = 1'h0, prog_addr_ok_o, prog_upper_o;
   logic               rvalid_o, win_sel_o, addr_trap_o;
   logic [22:0]        pc_load_val_i = '0, vec_index_i = '0, program_counter_o;
   logic [7:0]         table_page_register_i = '0, byte_i = '0;
   logic [15:0]        tbl_offset_i = '0, wreg_i = '0, d;
   logic [15:0]        rdata_o, rd_ptr_o, wr_ptr_o, wreg_o;
   logic [14:0]        win_page_i = '0;
   logic [1:0]         ext_op_i = '0;
   logic [23:0]        prog_addr_o, vec_addr_o;
   mem_map_pkg::psrc_e psrc_i = mem_map_pkg::PSRC_PC;
   mem_map_pkg::dreq_s rd_req_i, wr_req_i;
   int                 err_total = 0, n_compared = 0;
   // Clock at 40 MHz
   always #12.5 clk_i = ~clk_i;
   memory_map_access_align dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .pc_step_i(pc_step_i), .pc_down_i(pc_down_i), .pc_load_i(pc_load_i),
      .pc_load_val_i(pc_load_val_i), .psrc_i(psrc_i), .win_page_i(win_page_i),
      .table_page_register_i(table_page_register_i), .tbl_offset_i(tbl_offset_i),
      .vec_index_i(vec_index_i), .vec_alt_i(vec_alt_i), .rd_req_i(rd_req_i),
      .prog_addr_o(prog_addr_o), .prog_addr_ok_o(prog_addr_ok_o),
      .prog_upper_o(prog_upper_o), .vec_addr_o(vec_addr_o), .rdata_o(rdata_o),
      .program_counter_o(program_counter_o), .wr_req_i(wr_req_i),
      .trap_ack_i(trap_ack_i), .rvalid_o(rvalid_o), .win_sel_o(win_sel_o),
      .rd_ptr_o(rd_ptr_o), .wr_ptr_o(wr_ptr_o), .addr_trap_o(addr_trap_o),
      .wreg_i(wreg_i), .byte_i(byte_i), .ext_op_i(ext_op_i), .wreg_o(wreg_o));
   core_model core_u (.clk_i(clk_i), .rdata_i(rdata_o), .rd_req_o(rd_req_i),
      .wr_req_o(wr_req_i));
   // Compare and count
   task chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Lanes, byte select and pointer step
   task t_lanes;
      core_u.wr(16'h0010, 16'hA55A, 1'h0);
      core_u.rd(16'h0010, 1'h0, d); chk(d, 16'hA55A);
      core_u.rd(16'h0011, 1'h1, d); chk(d, 16'h00A5);
      chk(rd_ptr_o, 16'h0012);
      core_u.wr(16'h0010, 16'h3C3C, 1'h1);
      core_u.wr(16'h0011, 16'h7E7E, 1'h1);
      chk(wr_ptr_o, 16'h0012);
      core_u.rd(16'h0010, 1'h0, d); chk(d, 16'h7E3C);
      $display("lanes test done");
   endtask
   // Odd word write is dropped, odd read completes, ack clears
   task t_trap;
      core_u.wr(16'h0011, 16'hDEAD, 1'h0); chk(addr_trap_o, 1'h1);
      core_u.rd(16'h0011, 1'h0, d); chk(d, 16'h7E3C);
      chk(addr_trap_o, 1'h1);
      @(posedge clk_i) trap_ack_i <= 1'h1;
      @(posedge clk_i) trap_ack_i <= 1'h0;
      #1 chk(addr_trap_o, 1'h0);
      core_u.wr(16'h0400, 16'hFFFF, 1'h0);
      core_u.rd(16'h0400, 1'h0, d); chk(d, 16'h0000);
      core_u.rd(16'h8000, 1'h1, d); chk(d, 16'h0000);
      $display("trap test done");
   endtask
   // Counter steps, sources, limits and vectors
   task t_prog;
      @(posedge clk_i) {pc_load_i, pc_load_val_i} <= {1'h1, 23'h000100};
      @(posedge clk_i) {pc_load_i, pc_step_i} <= 2'h1;
      @(posedge clk_i) pc_down_i <= 1'h1;
      #1 chk(program_counter_o, 23'h000102);
      @(posedge clk_i) {pc_step_i, pc_down_i} <= 2'h0;
      #1 chk(prog_addr_o, 24'h000100);
      chk(prog_upper_o, 1'h0);
      @(posedge clk_i) begin
         psrc_i <= mem_map_pkg::PSRC_TBL;
         {table_page_register_i, tbl_offset_i} <= {8'h80, 16'h0001};
      end
      #1 chk({prog_upper_o, prog_addr_ok_o}, 2'h3);
      chk(prog_addr_o, 24'h800001);
      @(posedge clk_i) vec_index_i <= 23'h000001;
      #1 chk(vec_addr_o, 24'h000006);
      @(posedge clk_i) vec_alt_i <= 1'h1;
      #1 chk(vec_addr_o, 24'h000102);
      $display("program test done");
   endtask
   // Byte load, sign and zero extension
   task t_ext;
      @(posedge clk_i) {ext_op_i, wreg_i, byte_i} <= {2'h3, 16'h1234, 8'hAB};
      #1 chk(wreg_o, 16'h12AB);
      @(posedge clk_i) {ext_op_i, wreg_i, byte_i} <= {2'h1, 16'h1280, 8'h80};
      #1 chk(wreg_o, 16'hFF80);
      @(posedge clk_i) ext_op_i <= 2'h2;
      #1 chk(wreg_o, 16'h0080);
      $display("extend test done");
   endtask
   // Verdict and end of run
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Reset, then each scenario
   initial begin
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      #1 chk({program_counter_o, addr_trap_o}, 24'h000000);
      t_lanes();
      t_trap();
      t_prog();
      t_ext();
      print_verdict();
   end
   // Watchdog
   initial begin
      repeat (3000) @(posedge clk_i);
      err_total++;
      print_verdict();
   end
endmodule
